/* File: hdl/standby_wake_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module standby_wake_sequencer #(
  parameter int NUM_SOURCES = 8,
  parameter int NUM_TICK_SRC = 4
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [NUM_SOURCES-1:0] int_pending_latch_i,
  input wire logic wdt_irq_i,
  input wire logic stop_entry_i,
  input wire logic stop_release_i,
  input wire logic [NUM_TICK_SRC-1:0] tick_src_i,
  output standby_wake_pkg::clk_gate_t gate_o,
  output standby_wake_pkg::osc_en_t osc_en_o,
  output logic tg_clear_o,
  output logic resume_o,
  output logic vector_o,
  output logic tick_latch_set_o,
  output logic [1:0] mode_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  standby_wake_pkg::seq_state_t state;
  standby_wake_pkg::seq_state_t next_state;
  standby_wake_pkg::op_mode_t mode;
  standby_wake_pkg::osc_en_t next_osc;
  logic fast_ref_ext;
  logic global_int_enable;
  logic [NUM_SOURCES-1:0] per_source_int_enable;
  logic tick_timer_enable;
  logic tick_int_source_enable;
  logic [1:0] tick_source_select;
  logic [15:0] warmup_count;
  logic [15:0] warm_cnt;
  logic [NUM_TICK_SRC-1:0] tick_prev;
  logic wake_latch;
  logic tick_fall;
  logic ctrl_wr;
  logic light_req;
  logic deep_req;
  logic warm_done;

  ////////////////////////////////////////////////////////////////////////////
  // Wake detection, evaluated on the free-running clock.

  assign wake_latch = |(int_pending_latch_i & per_source_int_enable); // [R24]
  assign tick_fall = tick_prev[tick_source_select] & ~tick_src_i[tick_source_select]; // [R23]
  assign ctrl_wr = wr_i && (addr_i == standby_wake_pkg::SYS_CTRL_TWO_OFS);
  assign light_req = ctrl_wr && wdata_i[standby_wake_pkg::LIGHT_SLEEP_BIT]; // [R12]
  assign deep_req = ctrl_wr && wdata_i[standby_wake_pkg::DEEP_SLEEP_BIT]; // [R21]
  assign warm_done = (state == standby_wake_pkg::ST_WARM) && (warm_cnt <= 16'h0001);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_prev <= '0;
    end else begin
      tick_prev <= tick_src_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  always_comb begin
    next_state = state;
    unique case (state)
      standby_wake_pkg::ST_RUN: begin
        if (stop_entry_i) begin
          next_state = standby_wake_pkg::ST_STOP;
        end else if (light_req && !wake_latch && !wdt_irq_i) begin // [R13] [R14]
          next_state = standby_wake_pkg::ST_LIGHT;
        end else if (deep_req && !wdt_irq_i) begin // [R14]
          next_state = standby_wake_pkg::ST_DEEP;
        end
      end
      standby_wake_pkg::ST_LIGHT: begin
        if (wake_latch) begin
          next_state = standby_wake_pkg::ST_RUN; // [R15]
        end
      end
      standby_wake_pkg::ST_DEEP: begin
        if (tick_fall) begin
          next_state = standby_wake_pkg::ST_RUN; // [R22]
        end
      end
      standby_wake_pkg::ST_STOP: begin
        if (stop_release_i) begin
          next_state = standby_wake_pkg::ST_WARM; // [R1]
        end
      end
      standby_wake_pkg::ST_WARM: begin
        if (warm_done) begin
          next_state = standby_wake_pkg::ST_RUN; // [R3]
        end
      end
      default: begin
        next_state = standby_wake_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= standby_wake_pkg::ST_WARM; // [R16]
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warm-up counter.

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warm_cnt <= standby_wake_pkg::WARMUP_RESET; // [R16]
    end else if (state == standby_wake_pkg::ST_STOP && stop_release_i) begin
      warm_cnt <= (warmup_count == 16'h0000) ? 16'h0001 : warmup_count; // [R2]
    end else if (state == standby_wake_pkg::ST_WARM && warm_cnt != 16'h0000) begin
      warm_cnt <= warm_cnt - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator enables, following the mode and fast reference held in stop.

  always_comb begin
    next_osc = '0;
    if (next_state != standby_wake_pkg::ST_STOP) begin
      next_osc.int_hf = (mode != standby_wake_pkg::MODE_SLOW) && !fast_ref_ext; // [R4] [R8]
      next_osc.ext_hf = (mode != standby_wake_pkg::MODE_SLOW) && fast_ref_ext; // [R5] [R8]
      next_osc.ext_lf = (mode != standby_wake_pkg::MODE_SINGLE_FAST); // [R6] [R7]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_en_o <= 3'b100;
    end else begin
      osc_en_o <= next_osc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating; state is frozen by stopping the CPU, not by clearing it.

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gate_o <= '0;
    end else begin
      gate_o.cpu_run <= (next_state == standby_wake_pkg::ST_RUN); // [R1] [R10] [R20]
      gate_o.wdt_run <= (next_state == standby_wake_pkg::ST_RUN); // [R9]
      gate_o.periph_clk_en <= (next_state == standby_wake_pkg::ST_RUN) ||
                              (next_state == standby_wake_pkg::ST_LIGHT); // [R9] [R19]
      gate_o.tick_clk_en <= (next_state != standby_wake_pkg::ST_STOP) &&
                            (next_state != standby_wake_pkg::ST_WARM); // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake pulses toward the CPU core and timers.

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resume_o <= 1'b0;
      vector_o <= 1'b0;
      tg_clear_o <= 1'b0;
      tick_latch_set_o <= 1'b0;
    end else begin
      resume_o <= (state != standby_wake_pkg::ST_RUN) &&
                  (next_state == standby_wake_pkg::ST_RUN); // [R3] [R15]
      vector_o <= ((state == standby_wake_pkg::ST_LIGHT) && wake_latch &&
                   global_int_enable) || // [R17] [R18]
                  ((state == standby_wake_pkg::ST_DEEP) && tick_fall && global_int_enable &&
                   tick_int_source_enable && tick_timer_enable);
      tg_clear_o <= warm_done; // [R3]
      tick_latch_set_o <= (state == standby_wake_pkg::ST_DEEP) && tick_fall &&
                          tick_timer_enable; // [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode <= standby_wake_pkg::MODE_SINGLE_FAST; // [R16]
      fast_ref_ext <= 1'b0;
    end else if (ctrl_wr && state == standby_wake_pkg::ST_RUN) begin
      fast_ref_ext <= wdata_i[standby_wake_pkg::FAST_REF_EXT_BIT];
      if (wdata_i[standby_wake_pkg::MODE_LSB+1 -: 2] != 2'b11) begin
        mode <= standby_wake_pkg::op_mode_t'(wdata_i[standby_wake_pkg::MODE_LSB+1 -: 2]);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      global_int_enable <= 1'b0;
      per_source_int_enable <= '0;
    end else if (wr_i && addr_i == standby_wake_pkg::INT_ENABLE_OFS) begin
      global_int_enable <= wdata_i[standby_wake_pkg::GLOBAL_INT_BIT];
      per_source_int_enable <= wdata_i[standby_wake_pkg::SOURCE_EN_LSB +: NUM_SOURCES];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_timer_enable <= 1'b0;
      tick_source_select <= 2'b00;
      tick_int_source_enable <= 1'b0;
    end else if (wr_i && addr_i == standby_wake_pkg::TICK_TIMER_CONTROL_OFS) begin
      tick_timer_enable <= wdata_i[standby_wake_pkg::TICK_ENABLE_BIT];
      tick_source_select <= wdata_i[standby_wake_pkg::TICK_SEL_LSB +: 2];
      tick_int_source_enable <= wdata_i[standby_wake_pkg::TICK_INT_SRC_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      warmup_count <= standby_wake_pkg::WARMUP_RESET;
    end else if (wr_i && addr_i == standby_wake_pkg::WARMUP_COUNT_OFS) begin
      warmup_count <= wdata_i[15:0]; // [R2]
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      unique case (addr_i)
        standby_wake_pkg::SYS_CTRL_TWO_OFS: begin
          rdata_o <= {27'h0000000, mode, fast_ref_ext,
                      state == standby_wake_pkg::ST_DEEP,
                      state == standby_wake_pkg::ST_LIGHT};
        end
        standby_wake_pkg::INT_ENABLE_OFS: begin
          rdata_o <= {{(24-NUM_SOURCES){1'b0}}, per_source_int_enable, 7'h00,
                      global_int_enable};
        end
        standby_wake_pkg::TICK_TIMER_CONTROL_OFS: begin
          rdata_o <= {28'h0000000, tick_int_source_enable, tick_source_select,
                      tick_timer_enable};
        end
        standby_wake_pkg::WARMUP_COUNT_OFS: begin
          rdata_o <= {16'h0000, warmup_count};
        end
        standby_wake_pkg::STATUS_OFS: begin
          rdata_o <= {16'h0000, warm_cnt[12:0], state};
        end
        default: begin
          rdata_o <= standby_wake_pkg::UNMAPPED_READ;
        end
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  assign mode_o = mode;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_light_refused: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R13]
    (state == standby_wake_pkg::ST_RUN && light_req && !stop_entry_i && (wake_latch || wdt_irq_i))
    |=> state != standby_wake_pkg::ST_LIGHT)
    else $error("light sleep entered despite pending wake");

  a_light_entry: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R12]
    (state == standby_wake_pkg::ST_RUN && light_req && !stop_entry_i && !wake_latch && !wdt_irq_i)
    |=> state == standby_wake_pkg::ST_LIGHT ##0 !gate_o.cpu_run && !gate_o.wdt_run
    && gate_o.periph_clk_en)
    else $error("light sleep entry wrong");

  a_light_wake: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R15]
    (state == standby_wake_pkg::ST_LIGHT && wake_latch)
    |=> state == standby_wake_pkg::ST_RUN && resume_o && vector_o == $past(global_int_enable))
    else $error("light sleep wake wrong");

  a_deep_gating: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R19]
    $past(state) == standby_wake_pkg::ST_DEEP && state == standby_wake_pkg::ST_DEEP
    |-> !gate_o.periph_clk_en && gate_o.tick_clk_en && !gate_o.cpu_run)
    else $error("deep sleep gating wrong");

  a_tick_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R22]
    (state == standby_wake_pkg::ST_DEEP && tick_fall)
    |=> tick_latch_set_o == $past(tick_timer_enable) && state == standby_wake_pkg::ST_RUN)
    else $error("deep sleep wake wrong");

  a_warm_load: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R2]
    (state == standby_wake_pkg::ST_STOP && stop_release_i && warmup_count == 16'h0003)
    |=> state == standby_wake_pkg::ST_WARM [*3] ##1 state == standby_wake_pkg::ST_RUN
    && tg_clear_o && resume_o)
    else $error("warm-up length wrong");

  a_warm_frozen: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R1]
    $past(state) == standby_wake_pkg::ST_WARM && state == standby_wake_pkg::ST_WARM
    |-> !gate_o.cpu_run && !gate_o.periph_clk_en)
    else $error("cpu runs during warm-up");

  a_slow_osc: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R8]
    (state == standby_wake_pkg::ST_STOP && stop_release_i && mode == standby_wake_pkg::MODE_SLOW)
    |=> !osc_en_o.int_hf && !osc_en_o.ext_hf && osc_en_o.ext_lf)
    else $error("slow mode oscillator restart wrong");

  a_single_osc: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [R7]
    (state == standby_wake_pkg::ST_STOP && stop_release_i &&
     mode == standby_wake_pkg::MODE_SINGLE_FAST)
    |=> !osc_en_o.ext_lf && (osc_en_o.int_hf != osc_en_o.ext_hf))
    else $error("single clock oscillator restart wrong");

endmodule : standby_wake_sequencer
`default_nettype wire

/* File: include/standby_wake_pkg.sv */
// Overview of operation
// R1: Stop wake restarts needed oscillators, then warm-up; everything stays frozen meanwhile.
// R2: Warm-up length comes from the software-written warm-up count.
// R3: After warm-up, resume at next instruction and clear prescaler and divider.
// R4: Internal fast reference at stop: only internal fast oscillator restarts.
// R5: External fast reference at stop: only external fast oscillator restarts.
// R6: Dual-clock fast mode at stop: slow external oscillator restarts too.
// R7: Single-clock fast mode at stop: slow external oscillator stays off.
// R8: Slow mode at stop: no fast oscillator starts, only slow external one.
// R9: Light sleep halts CPU and watchdog; other peripherals keep running.
// R10: Light sleep holds memory, registers, status and port latches unchanged.
// R11: Software clears global enable and enables wake sources before light sleep.
// R12: Writing one to the light sleep bit enters light sleep.
// R13: A wake condition already true refuses light sleep; bit stays clear.
// R14: A watchdog interrupt just before entry is serviced and sleep is abandoned.
// R15: Light sleep wake clears its bit and returns to the prior mode.
// R16: Any reset ends sleep, runs warm-up, then enters single-clock fast mode.
// R17: Global enable zero: enabled latch wakes, resume without vectoring, software clears latch.
// R18: Global enable one: enabled latch wakes, interrupt serviced first, then resume.
// R19: Deep sleep removes clock from all peripherals except the tick timer.
// R20: Deep sleep holds memory, registers, status and port latches unchanged.
// R21: Software disables peripherals; writing one to deep sleep bit enters deep sleep.
// R22: Deep sleep wake clears bit, restores mode, sets tick latch if enabled.
// R23: Deep sleep wakes on falling edge of the selected tick source clock.
// R24: Wake conditions are evaluated by logic that is never gated.
package standby_wake_pkg;

  localparam logic [7:0] SYS_CTRL_TWO_OFS = 8'h00;
  localparam logic [7:0] INT_ENABLE_OFS = 8'h04;
  localparam logic [7:0] TICK_TIMER_CONTROL_OFS = 8'h08;
  localparam logic [7:0] WARMUP_COUNT_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  localparam int LIGHT_SLEEP_BIT = 0;
  localparam int DEEP_SLEEP_BIT = 1;
  localparam int FAST_REF_EXT_BIT = 2;
  localparam int MODE_LSB = 3;
  localparam int GLOBAL_INT_BIT = 0;
  localparam int SOURCE_EN_LSB = 8;
  localparam int TICK_ENABLE_BIT = 0;
  localparam int TICK_SEL_LSB = 1;
  localparam int TICK_INT_SRC_BIT = 3;

  localparam logic [15:0] WARMUP_RESET = 16'h0010;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_SINGLE_FAST = 2'b00,
    MODE_DUAL_FAST = 2'b01,
    MODE_SLOW = 2'b10
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_LIGHT = 3'b001,
    ST_DEEP = 3'b010,
    ST_STOP = 3'b011,
    ST_WARM = 3'b100
  } seq_state_t;

  typedef struct packed {
    logic int_hf;
    logic ext_hf;
    logic ext_lf;
  } osc_en_t;

  typedef struct packed {
    logic cpu_run;
    logic wdt_run;
    logic periph_clk_en;
    logic tick_clk_en;
  } clk_gate_t;

endpackage : standby_wake_pkg

/* File: tb/test_standby_wake_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module test_standby_wake_sequencer;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [7:0] pend = 8'h00;
  logic wdt = 1'b0;
  logic stop_in = 1'b0;
  logic stop_rel = 1'b0;
  logic [3:0] tsrc = 4'hf;
  standby_wake_pkg::clk_gate_t gate;
  standby_wake_pkg::osc_en_t osc;
  logic tg_clear;
  logic resume;
  logic vector;
  logic tick_set;
  logic [1:0] mode;
  logic [31:0] seed = 32'h0000_4ad3;
  logic [31:0] rv;
  logic [1:0] m;
  logic x;
  logic te;
  logic tie;
  logic gie;
  logic [2:0] src;
  logic [31:0] n;
  int cyc;
  int ofs;
  int errors = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  standby_wake_sequencer i_dut (
    .clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .int_pending_latch_i(pend), .wdt_irq_i(wdt), .stop_entry_i(stop_in),
    .stop_release_i(stop_rel), .tick_src_i(tsrc), .gate_o(gate), .osc_en_o(osc),
    .tg_clear_o(tg_clear), .resume_o(resume), .vector_o(vector), .tick_latch_set_o(tick_set),
    .mode_o(mode)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] osc_exp(input logic [1:0] md, input logic ext);
    return {29'h0, (md != 2'b10) & ~ext, (md != 2'b10) & ext, md != 2'b00};
  endfunction : osc_exp

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic wait_resume(output int k);
    k = 0;
    while (resume !== 1'b1 && k < 64) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_flag(resume, 1'b1);
  endtask : wait_resume

  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    results();
  end

  initial begin
    tick(16);
    chk_word({28'h0, gate}, 32'h0);
    chk_word({29'h0, osc}, 32'h4);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_resume(cyc);
    chk_flag(tg_clear, 1'b1);
    chk_word({28'h0, gate}, 32'hf);
    bus_rd(standby_wake_pkg::WARMUP_COUNT_OFS, rv);
    chk_word(rv, 32'h10);
    bus_rd(8'h3c, rv);
    chk_word(rv, 32'h0);
    // Stop and warm-up for every mode and fast reference.
    for (int k = 0; k < 5; k++) begin
      m = (k < 2) ? 2'b00 : ((k < 4) ? 2'b01 : 2'b10);
      x = k[0] & (k < 4);
      seed = lfsr(seed);
      n = (k == 2) ? 32'h0000_0003 : ((k == 4) ? 32'h0000_0000 : {29'h0, seed[2:0]} + 32'h1);
      bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, {27'h0, m, x, 2'b00});
      bus_wr(standby_wake_pkg::WARMUP_COUNT_OFS, n);
      @(posedge clk);
      stop_in <= 1'b1;
      @(posedge clk);
      stop_in <= 1'b0;
      tick(2);
      chk_word({29'h0, osc}, 32'h0);
      @(posedge clk);
      stop_rel <= 1'b1;
      @(posedge clk);
      stop_rel <= 1'b0;
      #1;
      chk_word({28'h0, gate}, 32'h0);
      wait_resume(cyc);
      if (k == 0) begin
        ofs = cyc - n;
        chk_flag(ofs >= 0 && ofs <= 2, 1'b1);
      end
      chk_word(cyc, (n == 32'h0) ? 32'h1 : n);
      chk_flag(tg_clear, 1'b1);
      chk_word({29'h0, osc}, osc_exp(m, x));
    end
    // Light sleep entry and wake with both global enable settings.
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      src = seed[2:0];
      m = (seed[4:3] == 2'b11) ? 2'b01 : seed[4:3];
      bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, {27'h0, m, 3'b000});
      bus_wr(standby_wake_pkg::INT_ENABLE_OFS, {16'h0, 8'h01 << src, 7'h0, k[0]});
      bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, {27'h0, m, 3'b001});
      tick(2);
      chk_word({28'h0, gate}, 32'h3);
      bus_rd(standby_wake_pkg::STATUS_OFS, rv);
      chk_word({29'h0, rv[2:0]}, 32'h1);
      bus_rd(standby_wake_pkg::SYS_CTRL_TWO_OFS, rv);
      chk_flag(rv[0], 1'b1);
      @(posedge clk);
      pend <= ~(8'h01 << src);
      tick(3);
      chk_word({28'h0, gate}, 32'h3);
      @(posedge clk);
      pend <= 8'hff;
      wait_resume(cyc);
      chk_flag(vector, k[0]);
      chk_word({30'h0, mode}, {30'h0, m});
      @(posedge clk);
      pend <= 8'h00;
      #1;
      chk_word({28'h0, gate}, 32'hf);
      bus_rd(standby_wake_pkg::SYS_CTRL_TWO_OFS, rv);
      chk_flag(rv[0], 1'b0);
    end
    // Requests refused by a watchdog interrupt or an already pending wake.
    bus_wr(standby_wake_pkg::INT_ENABLE_OFS, 32'h0000_0100);
    @(posedge clk);
    wdt <= 1'b1;
    bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, 32'h1);
    bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, 32'h2);
    tick(2);
    chk_word({28'h0, gate}, 32'hf);
    bus_rd(standby_wake_pkg::SYS_CTRL_TWO_OFS, rv);
    chk_word({30'h0, rv[1:0]}, 32'h0);
    @(posedge clk);
    wdt <= 1'b0;
    pend <= 8'h01;
    bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, 32'h1);
    tick(2);
    chk_word({28'h0, gate}, 32'hf);
    bus_rd(standby_wake_pkg::SYS_CTRL_TWO_OFS, rv);
    chk_flag(rv[0], 1'b0);
    @(posedge clk);
    pend <= 8'h00;
    // Deep sleep woken by each tick source select.
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      te = seed[0];
      tie = seed[1];
      gie = seed[2];
      bus_wr(standby_wake_pkg::TICK_TIMER_CONTROL_OFS, {28'h0, tie, k[1:0], te});
      bus_wr(standby_wake_pkg::INT_ENABLE_OFS, {31'h0, gie});
      bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, 32'h2);
      tick(2);
      chk_word({28'h0, gate}, 32'h1);
      @(posedge clk);
      tsrc <= ~(4'h1 << (k[1:0] + 2'd1));
      tick(3);
      chk_word({28'h0, gate}, 32'h1);
      @(posedge clk);
      tsrc <= ~(4'h1 << k[1:0]);
      wait_resume(cyc);
      chk_flag(tick_set, te);
      chk_flag(vector, gie & tie & te);
      @(posedge clk);
      tsrc <= 4'hf;
      bus_rd(standby_wake_pkg::SYS_CTRL_TWO_OFS, rv);
      chk_flag(rv[1], 1'b0);
      chk_word({28'h0, gate}, 32'hf);
    end
    // Reset in the middle of light sleep from the dual-clock mode.
    bus_wr(standby_wake_pkg::INT_ENABLE_OFS, 32'h0);
    bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, 32'h8);
    bus_wr(standby_wake_pkg::SYS_CTRL_TWO_OFS, 32'h9);
    tick(2);
    @(posedge clk);
    rst_b <= 1'b0;
    tick(2);
    chk_word({28'h0, gate}, 32'h0);
    chk_word({29'h0, osc}, 32'h4);
    @(posedge clk);
    rst_b <= 1'b1;
    wait_resume(cyc);
    chk_flag(tg_clear, 1'b1);
    chk_word({30'h0, mode}, 32'h0);
    results();
  end
endmodule : test_standby_wake_sequencer
`default_nettype wire
